// file: hdl/jtap_cfg.svh
`ifndef JTAP_CFG_SVH
`define JTAP_CFG_SVH
// instruction register
`define JTAP_IR_W 10
`define JTAP_IR_CAPTURE 10'h001
`define JTAP_OP_EXTEST 10'h000
`define JTAP_OP_SAMPLE 10'h055
`define JTAP_OP_IDCODE 10'h059
`define JTAP_OP_USERCODE 10'h079
`define JTAP_OP_SIGREAD 10'h065
`define JTAP_OP_BYPASS 10'h3ff
// data registers
`define JTAP_ID_W 32
`define JTAP_USER_W 32
`define JTAP_SIG_W 16
`define JTAP_BSR_LEN 96
// identification word fields, values arbitrary
`define JTAP_ID_VERSION 4'h3
`define JTAP_ID_PART 16'h1234
`define JTAP_ID_MAKER 11'h2a5
`define JTAP_ID_LSB 1'h1
`endif

// file: hdl/jtap_pkg.sv
package jtap_pkg;
  // link pins as sampled from outside
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtap_pins_t;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jtap_state_t;
endpackage

// file: hdl/jtap_tap.sv
`timescale 1ns/1ps
`include "jtap_cfg.svh"
// Contract
// - instruction register is 10 bits, shifted from tdi, applied on update.
// - bypass instruction puts one-bit register between tdi and tdo.
// - sample/preload captures pins without disturbing them; pattern may be preloaded.
// - external test drives updated pattern to pins, captures input pins.
// - identification instruction shifts out captured 32-bit identification word.
// - identification word is version 4, part 16, maker 11, one bit.
// - identification word least significant bit is always one.
// - user-code instruction shifts out 32-bit user code where supported.
// - user code register is exactly 32 bits.
// - signature-read instruction shifts out user signature register on older variants.
// - user signature register is exactly 16 bits.
// - boundary chain length is a per-variant parameter.
// - test port unused means its pins are released as user pins.
// - shift time is set by tck rate and number of tck cycles.
module jtap_tap
  import jtap_pkg::*;
#(
  parameter int BSR_LEN = `JTAP_BSR_LEN,
  parameter bit HAS_USERCODE = 1'b1,
  parameter bit HAS_SIGREAD = 1'b0
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // test link pins
  input wire jtap_pins_t pins_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  // configuration
  input wire logic tap_enable_in,
  input wire logic [`JTAP_USER_W-1:0] user_code_in,
  input wire logic [`JTAP_SIG_W-1:0] user_signature_in,
  // device pins around the boundary chain
  input wire logic [BSR_LEN-1:0] pin_in_in,
  input wire logic [BSR_LEN-1:0] core_out_in,
  output logic [BSR_LEN-1:0] pin_out_out,
  output logic pins_released_out
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic jtap_state_t tap_next(input jtap_state_t s, input logic m);
    case (s)
      ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
      ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      default: tap_next = ST_RESET;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers, third tck stage for edges
  jtap_pins_t pins_s1;
  jtap_pins_t pins_s2;
  logic tck_s3;
  logic [BSR_LEN-1:0] pin_s1;
  logic [BSR_LEN-1:0] pin_s2;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      tck_s3 <= 1'b0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pins_s1 <= pins_in;
      pins_s2 <= pins_s1;
      tck_s3 <= pins_s2.tck;
      pin_s1 <= pin_in_in;
      pin_s2 <= pin_s1;
    end
  end

  wire tck_rise = pins_s2.tck & ~tck_s3;
  wire tck_fall = ~pins_s2.tck & tck_s3;

  ////////////////////////////////////////////////////////////////////////////
  jtap_state_t state;
  logic [`JTAP_IR_W-1:0] ir;
  logic [`JTAP_IR_W-1:0] ir_sh;
  logic bypass;
  logic [`JTAP_ID_W-1:0] id_sh;
  logic [`JTAP_USER_W-1:0] user_sh;
  logic [`JTAP_SIG_W-1:0] sig_sh;
  logic [BSR_LEN-1:0] bsr_sh;
  logic [BSR_LEN-1:0] bsr_upd;

  wire [`JTAP_ID_W-1:0] id_word = {`JTAP_ID_VERSION, `JTAP_ID_PART, `JTAP_ID_MAKER, `JTAP_ID_LSB};

  wire sel_extest = (ir == `JTAP_OP_EXTEST);
  wire sel_sample = (ir == `JTAP_OP_SAMPLE);
  wire sel_id = (ir == `JTAP_OP_IDCODE);
  wire sel_user = HAS_USERCODE && (ir == `JTAP_OP_USERCODE);
  wire sel_sig = HAS_SIGREAD && (ir == `JTAP_OP_SIGREAD);
  wire sel_bsr = sel_extest | sel_sample;
  wire sel_bypass = ~(sel_bsr | sel_id | sel_user | sel_sig);

  wire in_cap_dr = tck_rise && (state == ST_CAP_DR);
  wire in_sh_dr = tck_rise && (state == ST_SH_DR);
  wire dr_serial = sel_bsr ? bsr_sh[0] : sel_id ? id_sh[0] : sel_user ? user_sh[0] :
                   sel_sig ? sig_sh[0] : bypass;
  wire tdi = pins_s2.tdi;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !tap_enable_in) begin
      state <= ST_RESET;
    end else if (tck_rise) begin
      state <= tap_next(state, pins_s2.tms);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !tap_enable_in || state == ST_RESET) begin
      ir_sh <= `JTAP_IR_CAPTURE;
      ir <= `JTAP_OP_IDCODE;
    end else begin
      if (tck_rise && state == ST_CAP_IR) begin
        ir_sh <= `JTAP_IR_CAPTURE;
      end else if (tck_rise && state == ST_SH_IR) begin
        ir_sh <= {tdi, ir_sh[`JTAP_IR_W-1:1]};
      end
      if (tck_fall && state == ST_UPD_IR) begin
        ir <= ir_sh;
      end
    end
  end

  // one bit per tck cycle in shift
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      bypass <= 1'b0;
      id_sh <= '0;
      user_sh <= '0;
      sig_sh <= '0;
    end else if (in_cap_dr) begin
      bypass <= 1'b0;
      id_sh <= id_word;
      user_sh <= user_code_in;
      sig_sh <= user_signature_in;
    end else if (in_sh_dr) begin
      if (sel_bypass) begin
        bypass <= tdi;
      end
      if (sel_id) begin
        id_sh <= {tdi, id_sh[`JTAP_ID_W-1:1]};
      end
      if (sel_user) begin
        user_sh <= {tdi, user_sh[`JTAP_USER_W-1:1]};
      end
      if (sel_sig) begin
        sig_sh <= {tdi, sig_sh[`JTAP_SIG_W-1:1]};
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      bsr_sh <= '0;
      bsr_upd <= '0;
    end else begin
      if (in_cap_dr && sel_bsr) begin
        bsr_sh <= pin_s2;
      end else if (in_sh_dr && sel_bsr) begin
        bsr_sh <= {tdi, bsr_sh[BSR_LEN-1:1]};
      end
      if (tck_fall && state == ST_UPD_DR && sel_bsr) begin
        bsr_upd <= bsr_sh;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire shifting = (state == ST_SH_DR) || (state == ST_SH_IR);
  wire next_tdo = (state == ST_SH_IR) ? ir_sh[0] : dr_serial;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tdo_out <= 1'b0;
      tdo_oe_out <= 1'b0;
      pin_out_out <= '0;
      pins_released_out <= 1'b1;
    end else begin
      if (tck_fall) begin
        tdo_out <= next_tdo;
        tdo_oe_out <= shifting && tap_enable_in;
      end else if (!tap_enable_in) begin
        tdo_oe_out <= 1'b0;
      end
      pin_out_out <= sel_extest ? bsr_upd : core_out_in;
      pins_released_out <= ~tap_enable_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_ir_update;
    (tck_fall && state == ST_UPD_IR && tap_enable_in) |=> (ir == $past(ir_sh));
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("instruction not applied on update");

  property p_bypass_path;
    (in_sh_dr && sel_bypass && tap_enable_in) |=> (bypass == $past(tdi));
  endproperty
  a_bypass_path: assert property (p_bypass_path) else $error("bypass stage wrong");

  property p_bypass_out;
    (tck_fall && state == ST_SH_DR && sel_bypass && tap_enable_in) |=> (tdo_out == $past(bypass));
  endproperty
  a_bypass_out: assert property (p_bypass_out) else $error("bypass stage not on tdo");

  property p_sample_quiet;
    !sel_extest |=> (pin_out_out == $past(core_out_in));
  endproperty
  a_sample_quiet: assert property (p_sample_quiet) else $error("pins disturbed outside external test");

  property p_extest_drive;
    sel_extest |=> (pin_out_out == $past(bsr_upd));
  endproperty
  a_extest_drive: assert property (p_extest_drive) else $error("test pattern not driven");

  property p_id_capture;
    (in_cap_dr && tap_enable_in) |=> (id_sh == id_word) && id_sh[0];
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("identification capture wrong");

  property p_user_capture;
    (in_cap_dr && tap_enable_in) |=> (user_sh == $past(user_code_in)) && (sig_sh == $past(user_signature_in));
  endproperty
  a_user_capture: assert property (p_user_capture) else $error("user code or signature capture wrong");

  property p_release;
    !tap_enable_in |=> !tdo_oe_out && pins_released_out && (state == ST_RESET);
  endproperty
  a_release: assert property (p_release) else $error("pins not released");

  property p_tdo_on_fall;
    (!tck_fall && tap_enable_in) |=> $stable(tdo_out);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo changed off falling edge");

  property p_reset_hold;
    (tck_rise && pins_s2.tms && state == ST_RESET) |=> (state == ST_RESET) && (ir == `JTAP_OP_IDCODE);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("controller left reset with tms high");

endmodule

// file: tb/jtap_host.sv
`timescale 1ns/1ps
module jtap_host
  import jtap_pkg::*;
(
  // clock
  input wire logic core_clk_in,
  // link pins
  output jtap_pins_t pins_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  initial pins_out = '0;

  ////////////////////////////////////////////////////////////////
  // shift time per tck
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    @(posedge core_clk_in) pins_out <= '{tck: 1'b0, tms: tms, tdi: tdi};
    repeat (4) @(posedge core_clk_in);
    pins_out.tck <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    // released line floats high through its pull-up
    tdo = tdo_oe_in ? tdo_in : 1'b1;
  endtask

  task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic b;
    int i;
    dout = '0;
    tick(1'b1, ~pins_out.tdi, b);
    if (ir) tick(1'b1, ~pins_out.tdi, b);
    tick(1'b0, ~pins_out.tdi, b);
    tick(1'b0, ~pins_out.tdi, b);
    for (i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, ~pins_out.tdi, b);
    tick(1'b0, ~pins_out.tdi, b);
    // tck stands low between frames
    @(posedge core_clk_in) pins_out.tck <= 1'b0;
    repeat (8) @(posedge core_clk_in);
  endtask
endmodule

// file: tb/jtag_boundary_scan_tap_tb.sv
`timescale 1ns/1ps
`include "jtap_cfg.svh"
module jtag_boundary_scan_tap_tb
  import jtap_pkg::*;
;
  logic clk, rst_n, tap_en, tdo, tdo_oe, released, old_tdo, old_tdo_oe;
  logic [31:0] user_code;
  logic [15:0] user_sig;
  logic [`JTAP_BSR_LEN-1:0] pin_in, core_out, pin_out;
  logic [127:0] d;
  logic [9:0] codes [3];
  jtap_pins_t pins, old_pins;
  int fails, num_checks;

  jtap_tap dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .pins_in(pins), .tdo_out(tdo),
    .tdo_oe_out(tdo_oe), .tap_enable_in(tap_en), .user_code_in(user_code), .user_signature_in(user_sig),
    .pin_in_in(pin_in), .core_out_in(core_out), .pin_out_out(pin_out), .pins_released_out(released));
  jtap_host host_u (.core_clk_in(clk), .pins_out(pins), .tdo_in(tdo), .tdo_oe_in(tdo_oe));
  // older variant: signature read, no user code
  jtap_tap #(.HAS_USERCODE(1'b0), .HAS_SIGREAD(1'b1)) dut_old_u (.core_clk_in(clk), .rst_n_in(rst_n),
    .pins_in(old_pins), .tdo_out(old_tdo), .tdo_oe_out(old_tdo_oe), .tap_enable_in(tap_en),
    .user_code_in(user_code), .user_signature_in(user_sig), .pin_in_in(pin_in), .core_out_in(core_out),
    .pin_out_out(), .pins_released_out());
  jtap_host host_old_u (.core_clk_in(clk), .pins_out(old_pins), .tdo_in(old_tdo), .tdo_oe_in(old_tdo_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic load_ir(input logic old, input logic [9:0] code);
    if (old) host_old_u.scan(1'b1, 10, 128'(code), d);
    else host_u.scan(1'b1, 10, 128'(code), d);
    check(128'(d[9:0]), 128'(`JTAP_IR_CAPTURE));
  endtask

  task automatic test_id;
    host_u.scan(1'b0, 40, 128'h5a, d);
    check(128'(d[39:0]), 128'({8'h5a, `JTAP_ID_VERSION, `JTAP_ID_PART, `JTAP_ID_MAKER, `JTAP_ID_LSB}));
    check(128'(d[0]), 128'h1);
    $display("test_id done");
  endtask

  task automatic test_bypass;
    int i;
    codes = '{`JTAP_OP_BYPASS, 10'h2a0, `JTAP_OP_SIGREAD};
    for (i = 0; i < 3; i++) begin
      load_ir(1'b0, codes[i]);
      host_u.scan(1'b0, 8, 128'hb5, d);
      check(128'(d[7:0]), 128'h6a);
    end
    $display("test_bypass done");
  endtask

  task automatic test_user;
    load_ir(1'b0, `JTAP_OP_USERCODE);
    host_u.scan(1'b0, 40, 128'hc3, d);
    check(128'(d[39:0]), 128'({8'hc3, user_code}));
    $display("test_user done");
  endtask

  task automatic test_bsr;
    load_ir(1'b0, `JTAP_OP_SAMPLE);
    host_u.scan(1'b0, 96, 128'h3c5a_c0de_7e81_2468_ace1_3579, d);
    check(128'(d[95:0]), 128'ha5c3_0f96_1234_5678_9abc_def0);
    check(128'(pin_out), 128'h1357_9bdf_2468_ace0_fdb9_7531);
    load_ir(1'b0, `JTAP_OP_EXTEST);
    repeat (4) @(posedge clk);
    check(128'(pin_out), 128'h3c5a_c0de_7e81_2468_ace1_3579);
    pin_in <= 96'h6b1d_e2f0_4c87_19a3_5d2e_b7c4;
    // one byte past the chain shows its length
    host_u.scan(1'b0, 104, 128'h81e7_4d26_9fb0_3ac5_1e6d_f248_5e, d);
    check(128'(d[103:0]), 128'h5e_6b1d_e2f0_4c87_19a3_5d2e_b7c4);
    check(128'(pin_out), 128'h81e7_4d26_9fb0_3ac5_1e6d_f248);
    load_ir(1'b0, `JTAP_OP_BYPASS);
    repeat (4) @(posedge clk);
    check(128'(pin_out), 128'h1357_9bdf_2468_ace0_fdb9_7531);
    $display("test_bsr done");
  endtask

  task automatic test_release;
    @(posedge clk) tap_en <= 1'b0;
    repeat (3) @(posedge clk);
    check(128'({released, tdo_oe}), 128'h2);
    tap_en <= 1'b1;
    repeat (4) @(posedge clk);
    check(128'(released), 128'h0);
    host_u.tick(1'b0, 1'b0, d[0]);
    host_u.scan(1'b0, 1, 128'h0, d);
    check(128'(d[0]), 128'h1);
    $display("test_release done");
  endtask

  task automatic test_old;
    host_old_u.tick(1'b0, 1'b0, d[0]);
    load_ir(1'b1, `JTAP_OP_SIGREAD);
    host_old_u.scan(1'b0, 24, 128'ha7, d);
    check(128'(d[23:0]), 128'({8'ha7, user_sig}));
    load_ir(1'b1, `JTAP_OP_USERCODE);
    host_old_u.scan(1'b0, 8, 128'hb5, d);
    check(128'(d[7:0]), 128'h6a);
    $display("test_old done");
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    tap_en = 1'b1;
    user_code = 32'h5aa5_c33c;
    user_sig = 16'h9e37;
    pin_in = 96'ha5c3_0f96_1234_5678_9abc_def0;
    core_out = 96'h1357_9bdf_2468_ace0_fdb9_7531;
    fails = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(128'(released), 128'h0);
    host_u.tick(1'b0, 1'b0, d[0]);
    test_id;
    test_bypass;
    test_user;
    test_bsr;
    test_release;
    test_old;
    print_verdict;
  end
endmodule
